// ===== core/fault_regs_pkg.sv
package fault_regs_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_GENERAL_FAULT = 8'h02;
  localparam logic [7:0] ADDR_LEFT_FAULT = 8'h03;
  localparam logic [7:0] ADDR_RIGHT_FAULT = 8'h04;
  localparam logic [7:0] ADDR_SUMMARY = 8'h05;
  localparam logic [7:0] ADDR_GENERAL_ENABLE = 8'h06;
  localparam logic [7:0] ADDR_LEFT_ENABLE = 8'h07;
  localparam logic [7:0] ADDR_RIGHT_ENABLE = 8'h08;

  // Reset value of every fault and mask register
  localparam logic [7:0] REG_RESET = 8'h00;
  // Answer on an unmapped or out-of-scope offset
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Implemented bit positions (all others read zero, ignore writes)
  localparam logic [7:0] GENERAL_BITS = 8'h70;
  localparam logic [7:0] CHANNEL_BITS = 8'hEC;

  // Field positions, general fault and general mask
  localparam int BIT_TEMP_WARNING = 6;
  localparam int BIT_THERMAL_SHUTDOWN = 5;
  localparam int BIT_OVERVOLTAGE = 4;

  // Field positions, per-channel fault and mask
  localparam int BIT_SHORT_SUPPLY = 7;
  localparam int BIT_SHORT_GROUND = 6;
  localparam int BIT_OVERCURRENT = 5;
  localparam int BIT_EXCESS_OFFSET = 3;
  localparam int BIT_OPEN_LOAD = 2;

  // Field positions, summary register
  localparam int SUM_FLAG = 7;
  localparam int SUM_LEFT_TRISTATED = 6;
  localparam int SUM_RIGHT_TRISTATED = 5;
  localparam int SUM_LEFT_OFFSET = 4;
  localparam int SUM_RIGHT_OFFSET = 3;

  // Device type code; value is arbitrary
  localparam logic [2:0] DEVICE_TYPE_CODE_DEFAULT = 3'h6;

  // Raw per-channel conditions from the analog detectors
  typedef struct packed {
    logic shortSupply;
    logic shortGround;
    logic overcurrent;
    logic excessOffset;
    logic openLoad;
  } chan_fault_s;

  // Raw device-wide conditions
  typedef struct packed {
    logic tempWarning;
    logic thermalShutdown;
    logic overvoltage;
  } general_fault_s;

  // One decoded register access from the serial interface engine
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } reg_req_s;

  // Places channel conditions at their register bit positions
  function automatic logic [7:0] chan_to_byte(input chan_fault_s f);
    chan_to_byte = {f.shortSupply, f.shortGround, f.overcurrent, 1'b0,
                    f.excessOffset, f.openLoad, 2'b00};
  endfunction

  // Places general conditions at their register bit positions
  function automatic logic [7:0] general_to_byte(input general_fault_s f);
    general_to_byte = {1'b0, f.tempWarning, f.thermalShutdown, f.overvoltage, 4'h0};
  endfunction

endpackage

// ===== core/channel_fault_reg.sv
module channel_fault_reg
  import fault_regs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input chan_fault_s faultIn, // Raw channel conditions
  input wire logic [7:0] enableMask, // Channel mask register
  input wire logic diagEnable, // Diagnostic mode on
  input wire logic readClear, // Register is being read
  output logic [7:0] status_d, // Next status value
  output logic [7:0] status_q // Sticky status register
);

  // Qualified detections at their bit positions
  logic [7:0] setBits;

  // Only enabled conditions in diagnostic mode are recorded
  assign setBits = chan_to_byte(faultIn) & enableMask & {8{diagEnable}}
                   & CHANNEL_BITS;

  // Set wins over the read clear so a fault in the read cycle survives
  assign status_d = (status_q & ~{8{readClear}}) | setBits;

  // Sticky fault bits, cleared at power-up
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_q <= REG_RESET;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // A qualified condition shows in the register on the next edge
  property p_set_recorded;
    @(posedge clk) disable iff (!reset_n)
      (diagEnable && faultIn.shortGround && enableMask[BIT_SHORT_GROUND])
      |=> status_q[BIT_SHORT_GROUND];
  endproperty
  a_set_recorded: assert property (p_set_recorded) else $error("short to ground lost");

  // Masked conditions never set a bit that was clear
  property p_masked_ignored;
    @(posedge clk) disable iff (!reset_n)
      (!enableMask[BIT_OPEN_LOAD] && !status_q[BIT_OPEN_LOAD])
      |=> !status_q[BIT_OPEN_LOAD];
  endproperty
  a_masked_ignored: assert property (p_masked_ignored) else $error("masked open load set");

  // A read with no new detection leaves the register empty
  property p_read_clears;
    @(posedge clk) disable iff (!reset_n)
      (readClear && setBits == 8'h00) |=> (status_q == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear");

  // Outside diagnostic mode nothing new is recorded
  property p_diagnostic_enable_gate;
    @(posedge clk) disable iff (!reset_n)
      (!diagEnable && readClear) |=> (status_q == 8'h00);
  endproperty
  a_diagnostic_enable_gate: assert property (p_diagnostic_enable_gate) else $error("fault recorded without diagnostics");

endmodule

// ===== core/fault_status_mask_registers.sv
// Summary of operation
// - general fault D6 on temperature warning
// - general fault D5 on thermal shutdown
// - general fault D4 on supply overvoltage
// - general faults recorded only when enabled
// - left fault D7 short supply, D6 ground
// - left fault D5 on left overcurrent
// - left D3 excess offset, D2 open load
// - left faults recorded only when enabled
// - fault flag low while left faults present
// - right fault D7 short supply, D6 ground
// - right D5 overcurrent, D3 offset, D2 open
// - right faults recorded only when enabled
// - fault flag low while right faults present
// - summary D7 mirrors fault flag low
// - summary D6/D5 show outputs tristated
// - summary D4/D3 mirror channel offset faults
// - summary D2..D0 fixed device type code
// - general mask D6, D5, D4; D7 zero
// - left mask D7, D6, D5 enables
// - left mask D3, D2; D4 zero
// - reading a channel fault register clears it
// - detection needs diagnostics and mask bit
// - fault flag is open drain, low active
module fault_status_mask_registers
  import fault_regs_pkg::*;
#(
  parameter logic [2:0] DEVICE_TYPE_CODE = DEVICE_TYPE_CODE_DEFAULT // Arbitrary value
)
(
  input wire logic clk, // System clock, 100 MHz
  input wire logic reset_n, // Power-on reset, active low
  input reg_req_s regReq, // Decoded register access
  output logic [7:0] regRdData_q, // Read data
  output logic regRdValid_q, // Read data valid pulse
  input wire logic diagEnable, // Diagnostic mode on
  input general_fault_s generalIn, // Raw device-wide conditions
  input chan_fault_s leftIn, // Raw left channel conditions
  input chan_fault_s rightIn, // Raw right channel conditions
  input wire logic leftOutputTristated, // Left output high impedance
  input wire logic rightOutputTristated, // Right output high impedance
  output logic faultFlagOut_q, // Fault pin level when driven
  output logic faultFlagOe_q // Fault pin pulled low
);

  // Mask registers
  logic [7:0] generalEnable_q;
  logic [7:0] leftEnable_q;
  logic [7:0] rightEnable_q;
  // General fault register
  logic [7:0] generalFault_q;
  logic [7:0] generalFault_d;
  // Channel fault registers
  logic [7:0] leftStatus_q;
  logic [7:0] leftStatus_d;
  logic [7:0] rightStatus_q;
  logic [7:0] rightStatus_d;
  // Summary register contents
  logic [7:0] summaryByte;
  // Address decode
  logic hitGeneralFault;
  logic hitLeftFault;
  logic hitRightFault;
  logic hitSummary;
  logic hitGeneralEnable;
  logic hitLeftEnable;
  logic hitRightEnable;
  // Access strobes
  logic rdStrobe;
  logic wrStrobe;
  logic leftReadClear;
  logic rightReadClear;
  // Selected read value
  logic [7:0] rdMux;
  // Any fault holding the pin low
  logic faultPresent_d;

  // Offset decode
  assign hitGeneralFault = (regReq.addr == ADDR_GENERAL_FAULT);
  assign hitLeftFault = (regReq.addr == ADDR_LEFT_FAULT);
  assign hitRightFault = (regReq.addr == ADDR_RIGHT_FAULT);
  assign hitSummary = (regReq.addr == ADDR_SUMMARY);
  assign hitGeneralEnable = (regReq.addr == ADDR_GENERAL_ENABLE);
  assign hitLeftEnable = (regReq.addr == ADDR_LEFT_ENABLE);
  assign hitRightEnable = (regReq.addr == ADDR_RIGHT_ENABLE);

  // A write in the same cycle as a read takes priority; reads stay pure
  assign wrStrobe = regReq.wrEn;
  assign rdStrobe = regReq.rdEn && !regReq.wrEn;

  // Read-clear strobes for the sticky channel registers
  assign leftReadClear = rdStrobe && hitLeftFault;
  assign rightReadClear = rdStrobe && hitRightFault;

  // General faults follow the qualified conditions; not sticky, not cleared
  assign generalFault_d = general_to_byte(generalIn) & generalEnable_q
                          & {8{diagEnable}} & GENERAL_BITS;

  // Per-channel views, index 0 left and index 1 right
  chan_fault_s [1:0] chanIn;
  logic [1:0][7:0] chanEnable;
  logic [1:0] chanReadClear;
  logic [1:0][7:0] chanStatus_d;
  logic [1:0][7:0] chanStatus_q;

  // Channel inputs gathered for the loop
  assign chanIn = {rightIn, leftIn};
  assign chanEnable = {rightEnable_q, leftEnable_q};
  assign chanReadClear = {rightReadClear, leftReadClear};

  // One sticky fault register per channel, same logic for both sides
  for (genvar ch = 0; ch < 2; ch++)
  begin : g_chan
    channel_fault_reg u_chan
    (
      .clk(clk),
      .reset_n(reset_n),
      .faultIn(chanIn[ch]),
      .enableMask(chanEnable[ch]),
      .diagEnable(diagEnable),
      .readClear(chanReadClear[ch]),
      .status_d(chanStatus_d[ch]),
      .status_q(chanStatus_q[ch])
    );
  end

  // Per-channel results back under their own names
  assign leftStatus_d = chanStatus_d[0];
  assign leftStatus_q = chanStatus_q[0];
  assign rightStatus_d = chanStatus_d[1];
  assign rightStatus_q = chanStatus_q[1];

  // Pin low whenever any fault register holds a one, from the next values
  // so the pin and the registers change on the same edge
  assign faultPresent_d = (|leftStatus_d) || (|rightStatus_d)
                          || (|generalFault_d);

  // Summary register assembled live; the flag bit tracks the pin
  assign summaryByte[SUM_FLAG] = faultFlagOe_q;
  assign summaryByte[SUM_LEFT_TRISTATED] = leftOutputTristated;
  assign summaryByte[SUM_RIGHT_TRISTATED] = rightOutputTristated;
  assign summaryByte[SUM_LEFT_OFFSET] = leftStatus_q[BIT_EXCESS_OFFSET];
  assign summaryByte[SUM_RIGHT_OFFSET] = rightStatus_q[BIT_EXCESS_OFFSET];
  assign summaryByte[2:0] = DEVICE_TYPE_CODE;

  // Read selection; unmapped offsets answer zero
  assign rdMux = hitGeneralFault ? generalFault_q :
                 hitLeftFault ? leftStatus_q :
                 hitRightFault ? rightStatus_q :
                 hitSummary ? summaryByte :
                 hitGeneralEnable ? generalEnable_q :
                 hitLeftEnable ? leftEnable_q :
                 hitRightEnable ? rightEnable_q :
                 UNMAPPED_READ;

  // General mask; only its three enables are writable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      generalEnable_q <= REG_RESET;
    end
    else if (wrStrobe && hitGeneralEnable)
    begin
      generalEnable_q <= regReq.wrData & GENERAL_BITS;
    end
  end

  // Left mask; D4 and D1..D0 stay zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      leftEnable_q <= REG_RESET;
    end
    else if (wrStrobe && hitLeftEnable)
    begin
      leftEnable_q <= regReq.wrData & CHANNEL_BITS;
    end
  end

  // Right mask, same layout as the left one
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rightEnable_q <= REG_RESET;
    end
    else if (wrStrobe && hitRightEnable)
    begin
      rightEnable_q <= regReq.wrData & CHANNEL_BITS;
    end
  end

  // General fault register; read-only, so no write path
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      generalFault_q <= REG_RESET;
    end
    else
    begin
      generalFault_q <= generalFault_d;
    end
  end

  // Read answer one cycle after the request; data is the pre-clear value
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdData_q <= REG_RESET;
      regRdValid_q <= 1'b0;
    end
    else
    begin
      regRdValid_q <= rdStrobe;
      if (rdStrobe)
      begin
        regRdData_q <= rdMux;
      end
    end
  end

  // Open-drain pin: level is always low, only the enable moves
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      faultFlagOut_q <= 1'b0;
      faultFlagOe_q <= 1'b0;
    end
    else
    begin
      faultFlagOut_q <= 1'b0;
      faultFlagOe_q <= faultPresent_d;
    end
  end

  // Temperature warning reaches D6 one edge after it qualifies
  property p_temp_warning;
    @(posedge clk) disable iff (!reset_n)
      (diagEnable && generalIn.tempWarning && generalEnable_q[BIT_TEMP_WARNING])
      |=> generalFault_q[BIT_TEMP_WARNING];
  endproperty
  a_temp_warning: assert property (p_temp_warning) else $error("warning not recorded");

  // Thermal shutdown reaches D5
  property p_thermal_shutdown;
    @(posedge clk) disable iff (!reset_n)
      (diagEnable && generalIn.thermalShutdown && generalEnable_q[BIT_THERMAL_SHUTDOWN])
      |=> generalFault_q[BIT_THERMAL_SHUTDOWN];
  endproperty
  a_thermal_shutdown: assert property (p_thermal_shutdown) else $error("shutdown lost");

  // Overvoltage reaches D4
  property p_overvoltage;
    @(posedge clk) disable iff (!reset_n)
      (diagEnable && generalIn.overvoltage && generalEnable_q[BIT_OVERVOLTAGE])
      |=> generalFault_q[BIT_OVERVOLTAGE];
  endproperty
  a_overvoltage: assert property (p_overvoltage) else $error("overvoltage lost");

  // A masked general condition never shows
  property p_general_masked;
    @(posedge clk) disable iff (!reset_n)
      !generalEnable_q[BIT_TEMP_WARNING] |=> !generalFault_q[BIT_TEMP_WARNING];
  endproperty
  a_general_masked: assert property (p_general_masked) else $error("masked warning set");

  // Pin enable follows any set left or right fault bit
  property p_flag_channels;
    @(posedge clk) disable iff (!reset_n)
      ((|leftStatus_q) || (|rightStatus_q)) |-> faultFlagOe_q;
  endproperty
  a_flag_channels: assert property (p_flag_channels) else $error("flag not low on fault");

  // Pin released when no fault register holds a one
  property p_flag_release;
    @(posedge clk) disable iff (!reset_n)
      faultFlagOe_q |-> ((|leftStatus_q) || (|rightStatus_q) || (|generalFault_q));
  endproperty
  a_flag_release: assert property (p_flag_release) else $error("flag low without fault");

  // Summary read shows the flag state and type code of the request cycle
  property p_summary_read;
    logic [7:0] expected;
    @(posedge clk) disable iff (!reset_n)
      (rdStrobe && hitSummary, expected = {faultFlagOe_q, leftOutputTristated,
        rightOutputTristated, leftStatus_q[BIT_EXCESS_OFFSET],
        rightStatus_q[BIT_EXCESS_OFFSET], DEVICE_TYPE_CODE})
      |=> (regRdValid_q && regRdData_q == expected);
  endproperty
  a_summary_read: assert property (p_summary_read) else $error("summary read wrong");

  // Mask write keeps only the documented enables
  property p_left_mask_write;
    @(posedge clk) disable iff (!reset_n)
      (wrStrobe && hitLeftEnable) |=> (leftEnable_q == ($past(regReq.wrData) & 8'hEC));
  endproperty
  a_left_mask_write: assert property (p_left_mask_write) else $error("left mask wrong");

  // General mask D7 and low nibble always read zero
  property p_general_mask_zero;
    @(posedge clk) disable iff (!reset_n)
      wrStrobe |=> (generalEnable_q[7] == 1'b0 && generalEnable_q[3:0] == 4'h0);
  endproperty
  a_general_mask_zero: assert property (p_general_mask_zero) else $error("mask bit stuck");

  // Read of the left register with diagnostics off clears it on the next edge; pin released unless another register holds a one
  property p_left_read_clear;
    @(posedge clk) disable iff (!reset_n)
      (leftReadClear && !diagEnable) |=> (leftStatus_q == 8'h00) ##0 !faultFlagOe_q[*1]
        or (rightStatus_q != 8'h00 || generalFault_q != 8'h00);
  endproperty
  a_left_read_clear: assert property (p_left_read_clear) else $error("left not cleared");

  // A condition present in the read cycle survives the clear
  property p_set_wins;
    @(posedge clk) disable iff (!reset_n)
      (leftReadClear && diagEnable && leftIn.openLoad && leftEnable_q[BIT_OPEN_LOAD])
      |=> leftStatus_q[BIT_OPEN_LOAD];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to read clear");

  // Pin level never leaves low; only the enable signals a fault
  property p_flag_level;
    @(posedge clk) disable iff (!reset_n)
      faultFlagOe_q |-> !faultFlagOut_q;
  endproperty
  a_flag_level: assert property (p_flag_level) else $error("flag driven high");

  // Right mask write keeps only the channel enables
  property p_right_enable_wr;
    @(posedge clk) disable iff (!reset_n)
      (wrStrobe && hitRightEnable)
      |=> (rightEnable_q == ($past(regReq.wrData) & CHANNEL_BITS));
  endproperty
  a_right_enable_wr: assert property (p_right_enable_wr) else $error("right mask bad");

  // Outside diagnostic mode the general register empties on the next edge
  property p_diagnostic_enable_general;
    @(posedge clk) disable iff (!reset_n)
      !diagEnable |=> (generalFault_q == 8'h00);
  endproperty
  a_diagnostic_enable_general: assert property (p_diagnostic_enable_general) else $error("general without diagnostic_enable");

endmodule

// ===== tb/reg_host_model.sv
// Host side of the register port: one decoded access at a time
module reg_host_model
  import fault_regs_pkg::*;
(
  input wire logic clk, // System clock
  output reg_req_s regReq, // Access toward the bank
  input wire logic [7:0] regRdData_q, // Read data
  input wire logic regRdValid_q // Read answer strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: no strobe, address and data left scrambled on purpose
  initial regReq = '{1'b0, 1'b0, 8'hA5, 8'h5A};

  // One write pulse; the host owns the masks
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    regReq <= '{1'b0, 1'b0, ~a, ~d};
  endtask

  // One read pulse, then a bounded wait for the answer strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int i;
    ok = 1'b0;
    d = 8'h00;
    @(posedge clk);
    regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    regReq <= '{1'b0, 1'b0, ~a, 8'hFF};
    for (i = 0; i < 4 && !ok; i++)
    begin
      // Sampled mid-cycle, away from the launching edge
      @(negedge clk);
      if (regRdValid_q === 1'b1)
      begin
        d = regRdData_q;
        ok = 1'b1;
      end
    end
  endtask
endmodule

// ===== tb/fault_status_mask_registers_tb.sv
// Self-checking bench for the fault register bank
module fault_status_mask_registers_tb;
  import fault_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [2:0] TYPE_CODE = 3'h3; // Arbitrary value
  localparam bit PIN_OE = 1'b1; // Check the pin enable
  localparam bit PIN_LEVEL = 1'b0; // Check the pin level
  logic clk = 1'b0; // 100 MHz
  logic reset_n; // Active low
  reg_req_s regReq; // From host model
  logic [7:0] regRdData_q; // Read data
  logic regRdValid_q; // Read strobe
  logic diagEnable; // Diagnostics on
  general_fault_s generalIn; // Device-wide conditions
  chan_fault_s leftIn; // Left conditions
  chan_fault_s rightIn; // Right conditions
  logic leftOutputTristated; // Left high-Z
  logic rightOutputTristated; // Right high-Z
  logic faultFlagOut_q; // Pin level
  logic faultFlagOe_q; // Pin pulled low
  int n_fail = 0; // Mismatches
  int num_checks = 0; // Comparisons

  // Clock: 5 ns half period
  always #5 clk = ~clk;

  fault_status_mask_registers #(.DEVICE_TYPE_CODE(TYPE_CODE)) uut (
    .clk(clk), .reset_n(reset_n), .regReq(regReq), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q), .diagEnable(diagEnable), .generalIn(generalIn),
    .leftIn(leftIn), .rightIn(rightIn), .leftOutputTristated(leftOutputTristated),
    .rightOutputTristated(rightOutputTristated), .faultFlagOut_q(faultFlagOut_q),
    .faultFlagOe_q(faultFlagOe_q));

  reg_host_model host (.clk(clk), .regReq(regReq), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q));

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Byte comparison
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pin comparison, read mid-cycle so the launching edge has settled
  task automatic check_pin(input string what, input logic exp, input bit pinOe);
    logic got;
    @(negedge clk);
    got = pinOe ? faultFlagOe_q : faultFlagOut_q;
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Read one register and compare; a missing answer ends the run
  task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    host.read_reg(a, d, ok);
    if (!ok)
    begin
      n_fail++;
      $display("[FAIL] %s expected answer seen none", what);
      report_and_stop();
    end
    else
    begin
      check_byte(what, exp, d);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Power-up values, type code, one unmapped offset
  task automatic test_reset();
    logic [7:0] zeroRegs [6] = '{8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08};
    foreach (zeroRegs[i])
      expect_reg("cleared register", zeroRegs[i], REG_RESET);
    expect_reg("summary", ADDR_SUMMARY, {5'h00, TYPE_CODE});
    expect_reg("unmapped", 8'h09, UNMAPPED_READ);
    check_pin("flag idle", 1'b0, PIN_OE);
    $display("test reset done");
  endtask

  // Writable bits of the general and left masks; read-only places ignore writes
  task automatic test_masks();
    host.write_reg(ADDR_GENERAL_ENABLE, 8'hFF);
    host.write_reg(ADDR_LEFT_ENABLE, 8'hFF);
    host.write_reg(ADDR_GENERAL_FAULT, 8'hFF);
    expect_reg("general mask", ADDR_GENERAL_ENABLE, 8'h70);
    expect_reg("left mask", ADDR_LEFT_ENABLE, 8'hEC);
    expect_reg("general fault ro", ADDR_GENERAL_FAULT, 8'h00);
    host.write_reg(ADDR_GENERAL_ENABLE, 8'h8F);
    host.write_reg(ADDR_LEFT_ENABLE, 8'h13);
    expect_reg("general mask unused", ADDR_GENERAL_ENABLE, 8'h00);
    expect_reg("left mask unused", ADDR_LEFT_ENABLE, 8'h00);
    $display("test masks done");
  endtask

  // Each general condition, then one masked off
  task automatic test_general();
    host.write_reg(ADDR_GENERAL_ENABLE, 8'h70);
    @(posedge clk);
    diagEnable <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      generalIn <= general_fault_s'(3'b100 >> i);
      tick(2);
      check_pin("flag general", 1'b1, PIN_OE);
      expect_reg("general fault", ADDR_GENERAL_FAULT, 8'h40 >> i);
      @(posedge clk);
      generalIn <= '0;
    end
    host.write_reg(ADDR_GENERAL_ENABLE, 8'h30);
    @(posedge clk);
    generalIn <= general_fault_s'(3'b100);
    tick(2);
    expect_reg("general masked", ADDR_GENERAL_FAULT, 8'h00);
    @(posedge clk);
    generalIn <= '0;
    $display("test general done");
  endtask

  // Every channel condition: sticky bit, pin, summary, clear on read
  task automatic test_channel(input bit right);
    logic [7:0] expBits [5] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04};
    logic [7:0] faultAddr;
    logic [7:0] sumExp;
    faultAddr = right ? ADDR_RIGHT_FAULT : ADDR_LEFT_FAULT;
    host.write_reg(right ? ADDR_RIGHT_ENABLE : ADDR_LEFT_ENABLE, 8'hEC);
    for (int i = 0; i < 5; i++)
    begin
      // Condition held two cycles then removed: the bit must stick
      @(posedge clk);
      if (right)
        rightIn <= chan_fault_s'(5'b10000 >> i);
      else
        leftIn <= chan_fault_s'(5'b10000 >> i);
      tick(2);
      leftIn <= '0;
      rightIn <= '0;
      check_pin("flag low", 1'b1, PIN_OE);
      check_pin("flag level", 1'b0, PIN_LEVEL);
      sumExp = {1'b1, 2'b00, (i == 3) && !right, (i == 3) && right, TYPE_CODE};
      expect_reg("summary fault", ADDR_SUMMARY, sumExp);
      expect_reg("chan fault", faultAddr, expBits[i]);
      expect_reg("chan cleared", faultAddr, 8'h00);
      check_pin("flag released", 1'b0, PIN_OE);
    end
    $display("test channel %0d done", right);
  endtask

  // Set beats read clear; then diagnostics off, masks off: nothing recorded
  task automatic test_gating();
    // Condition held through a read: the bit must survive that read
    @(posedge clk);
    leftIn <= chan_fault_s'(5'b00001);
    tick(2);
    expect_reg("set over clear", ADDR_LEFT_FAULT, 8'h04);
    @(posedge clk);
    leftIn <= '0;
    expect_reg("bit survived", ADDR_LEFT_FAULT, 8'h04);
    expect_reg("then cleared", ADDR_LEFT_FAULT, 8'h00);
    @(posedge clk);
    diagEnable <= 1'b0;
    generalIn <= '1;
    leftIn <= '1;
    tick(2);
    expect_reg("general diagnostic_enable off", ADDR_GENERAL_FAULT, 8'h00);
    expect_reg("left diagnostic_enable off", ADDR_LEFT_FAULT, 8'h00);
    host.write_reg(ADDR_LEFT_ENABLE, 8'h00);
    host.write_reg(ADDR_RIGHT_ENABLE, 8'h00);
    @(posedge clk);
    diagEnable <= 1'b1;
    generalIn <= '0;
    rightIn <= '1;
    tick(2);
    expect_reg("left masked", ADDR_LEFT_FAULT, 8'h00);
    expect_reg("right masked", ADDR_RIGHT_FAULT, 8'h00);
    check_pin("flag masked", 1'b0, PIN_OE);
    @(posedge clk);
    leftIn <= '0;
    rightIn <= '0;
    $display("test gating done");
  endtask

  // High-impedance indications in the summary
  task automatic test_tristate();
    @(posedge clk);
    leftOutputTristated <= 1'b1;
    expect_reg("left highz", ADDR_SUMMARY, {3'b010, 2'b00, TYPE_CODE});
    @(posedge clk);
    leftOutputTristated <= 1'b0;
    rightOutputTristated <= 1'b1;
    expect_reg("right highz", ADDR_SUMMARY, {3'b001, 2'b00, TYPE_CODE});
    $display("test tristate done");
  endtask

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    diagEnable = 1'b0;
    generalIn = '0;
    leftIn = '0;
    rightIn = '0;
    leftOutputTristated = 1'b0;
    rightOutputTristated = 1'b0;
    tick(2);
    reset_n <= 1'b1;
    test_reset();
    test_masks();
    test_general();
    test_channel(1'b0);
    test_channel(1'b1);
    test_gating();
    test_tristate();
    report_and_stop();
  end
endmodule
